// ---- sra_top.sv ----
// status register access unit: serial command decode and status register bank
// assumes spi mode 0 host, chip select high at least 40 ns between frames
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: reads 05h 35h 15h return registers one to three
// R2: writes 01h 31h 11h load registers one to three
// R3: registers four to six only through indirect commands
// R4: indirect access reaches all six registers
// R5: 65h plus select byte returns selected register
// R6: 71h plus select byte writes selected register
// R7: host sends an eight bit select byte
// R8: selects 01h to 06h map to registers one to six
// R9: other selects: writes ignored, reads return constant
// R10: power-up copies non-volatile values into flops
// R11: after 50h a write updates flops only
// R12: after 06h a write updates flops and copy
// R13: bit seven protection control, reset zero
// R14: bit six block size, zero 64k one 4k
// R15: bit five protection direction, reset zero
// R16: bits four to two protect extent, reset zero
// R17: bit one write enable latch, set by 06h
// R18: latch clear with no 50h enable rejects status register writes
// R19: bit zero busy flag while internal work runs
module sra_top
	import sra_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic       mosi_i,
	output logic            miso_o,
	output logic            miso_oe_o,
	output logic            reg_protect_ctl_lo_o,
	output logic            protect_granularity_o,
	output logic            protect_direction_o,
	output logic      [2:0] protect_extent_o,
	output logic            write_enable_latch_o,
	output logic            busy_flag_o
);

	// link-domain state, cleared while chip select is high
	typedef struct packed {
		sra_link_e  st;
		logic [7:0] cmd;
		logic [7:0] sel;
		logic [7:0] rd;
		logic       en_f;
		logic       ven_f;
		logic       wr_f;
		logic [2:0] wr_idx;
		logic [7:0] wr_data;
	} sra_lq_s;

	// core-domain state
	typedef struct packed {
		sra_core_e                   st;
		logic [2:0]                  idx;
		logic [7:0]                  cnt;
		logic [NUM_REGS-1:0][7:0]    vol;
		logic [NUM_REGS-1:0][7:0]    snap;
		logic                        write_enable_latch;
		logic                        ven;
		logic                        busy;
		logic                        cs_m;
		logic                        cs_s;
		logic                        cs_l;
		logic                        en_m;
		logic                        en_s;
		logic                        en_l;
		logic                        ven_m;
		logic                        ven_s;
		logic                        ven_l;
		logic                        wr_m;
		logic                        wr_s;
		logic                        wr_l;
		logic                        pend;
		logic [2:0]                  p_idx;
		logic [7:0]                  p_data;
	} sra_cq_s;

	sra_lq_s    l_q, l_d;
	sra_cq_s    c_q, c_d;
	logic [7:0] rx_byte;
	logic       rx_done;
	logic [7:0] nv_rd;
	logic       nv_we;
	logic [7:0] ld_val;
	logic [7:0] wr_val;
	logic       commit;
	logic       en_rise;
	logic       ven_rise;
	logic       wr_rise;

	function automatic logic sel_ok(input logic [7:0] s);
		sel_ok = (s >= SEL_FIRST) && (s <= SEL_LAST); // see R8
	endfunction

	// snapshot is frozen for the whole frame, so the link may read it freely
	function automatic logic [7:0] snap_at(input logic [7:0] s);
		logic [2:0] i;
		i = s[2:0] - 3'h1;
		if (sel_ok(s)) begin
			snap_at = c_q.snap[i];
		end else begin
			snap_at = RSV_READ; // see R9
		end
	endfunction

	// first register keeps its read-only bits zero in storage
	function automatic logic [7:0] mask_ro(input logic [2:0] i, input logic [7:0] v);
		mask_ro = (i == 3'h0) ? (v & ~SR1_RO_MASK) : v;
	endfunction

	sra_shift u_shift (
		.sck_i     (sck_i),
		.cs_n_i    (cs_n_i),
		.mosi_i    (mosi_i),
		.tx_byte_i (l_q.rd),
		.rx_byte_o (rx_byte),
		.rx_done_o (rx_done),
		.miso_o    (miso_o)
	);

	sra_nvstore u_nv (
		.clk_i     (clk_i),
		.we_i      (nv_we),
		.wr_idx_i  (c_q.p_idx),
		.wr_data_i (wr_val),
		.rd_idx_i  (c_q.idx),
		.rd_data_o (nv_rd)
	);

	// command decoder on the link clock, one step per received byte
	always_comb begin
		l_d = l_q;
		if (rx_done) begin
			case (l_q.st)
				S_CMD: begin
					l_d.cmd = rx_byte;
					l_d.st  = S_IGN;
					case (rx_byte)
						CMD_RD_SR1: begin
							l_d.rd = snap_at(SEL_SR1); // see R1
							l_d.st = S_OUT;
						end
						CMD_RD_SR2: begin
							l_d.rd = snap_at(SEL_SR2); // see R1
							l_d.st = S_OUT;
						end
						CMD_RD_SR3: begin
							l_d.rd = snap_at(SEL_SR3); // see R1
							l_d.st = S_OUT;
						end
						CMD_WR_SR1: begin
							l_d.sel = SEL_SR1; // see R2
							l_d.st  = S_DATA;
						end
						CMD_WR_SR2: begin
							l_d.sel = SEL_SR2; // see R2
							l_d.st  = S_DATA;
						end
						CMD_WR_SR3: begin
							l_d.sel = SEL_SR3; // see R2
							l_d.st  = S_DATA;
						end
						// only these two reach registers four to six
						CMD_RD_IND, CMD_WR_IND: begin
							l_d.st = S_SEL; // see R3
						end
						CMD_WREN: begin
							l_d.en_f = 1'b1;
						end
						CMD_VWREN: begin
							l_d.ven_f = 1'b1;
						end
						default: begin
							l_d.st = S_IGN;
						end
					endcase
				end
				// whole eight-bit select byte, same map for read and write
				S_SEL: begin
					l_d.sel = rx_byte; // see R7
					if (l_q.cmd == CMD_RD_IND) begin
						l_d.rd = snap_at(rx_byte); // see R4, see R5
						l_d.st = S_OUT;
					end else begin
						l_d.st = S_DATA; // see R6
					end
				end
				S_DATA: begin
					l_d.st = S_IGN;
					if (sel_ok(l_q.sel)) begin
						l_d.wr_f    = 1'b1; // see R6
						l_d.wr_idx  = l_q.sel[2:0] - 3'h1;
						l_d.wr_data = rx_byte;
					end
				end
				S_OUT: begin
					l_d.rd = l_q.rd; // same register repeats until deselect
				end
				default: begin
					l_d.st = S_IGN;
				end
			endcase
		end
	end

	// deselect is the link reset: the clock may stop outside frames
	always_ff @(posedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	assign miso_oe_o = !cs_n_i && (l_q.st == S_OUT);

	// crossing events: flags are levels held to frame end, edge found after sync
	assign en_rise  = c_q.en_s && !c_q.en_l;
	assign ven_rise = c_q.ven_s && !c_q.ven_l;
	assign wr_rise  = c_q.wr_s && !c_q.wr_l;
	assign commit   = (c_q.st == C_IDLE) && c_q.cs_s && !c_q.cs_l && c_q.pend;
	assign ld_val   = mask_ro(c_q.idx, nv_rd);
	assign wr_val   = mask_ro(c_q.p_idx, c_q.p_data);
	assign nv_we    = commit && c_q.write_enable_latch; // see R12

	// core: power-up load, write commit, non-volatile busy time
	always_comb begin
		c_d       = c_q;
		c_d.cs_m  = cs_n_i;
		c_d.cs_s  = c_q.cs_m;
		c_d.cs_l  = c_q.cs_s;
		c_d.en_m  = l_q.en_f;
		c_d.en_s  = c_q.en_m;
		c_d.en_l  = c_q.en_s;
		c_d.ven_m = l_q.ven_f;
		c_d.ven_s = c_q.ven_m;
		c_d.ven_l = c_q.ven_s;
		c_d.wr_m  = l_q.wr_f;
		c_d.wr_s  = c_q.wr_m;
		c_d.wr_l  = c_q.wr_s;
		// frame start: freeze what the link will shift out
		if (!c_q.cs_s && c_q.cs_l) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				c_d.snap[i] = c_q.vol[i];
			end
			c_d.snap[0][BIT_WEL]  = c_q.write_enable_latch; // see R17
			c_d.snap[0][BIT_BUSY] = c_q.busy; // see R19
		end
		// word is stable: the link holds it until deselect
		if (wr_rise) begin
			c_d.pend   = 1'b1;
			c_d.p_idx  = l_q.wr_idx;
			c_d.p_data = l_q.wr_data;
		end
		if (en_rise && c_q.st != C_NVWR) begin
			c_d.write_enable_latch = 1'b1; // see R17
		end
		if (ven_rise && c_q.st != C_NVWR) begin
			c_d.ven = 1'b1;
		end
		// a deselect ends the write command; pending word is used or dropped
		if (c_q.cs_s && !c_q.cs_l) begin
			c_d.pend = 1'b0;
		end
		case (c_q.st)
			C_LOAD: begin
				c_d.vol[c_q.idx] = ld_val; // see R10
				c_d.idx          = c_q.idx + 3'h1;
				if (c_q.idx == 3'(NUM_REGS - 1)) begin
					c_d.st   = C_IDLE;
					c_d.busy = 1'b0;
					c_d.idx  = 3'h0;
				end
			end
			C_IDLE: begin
				if (commit && c_q.write_enable_latch) begin
					c_d.vol[c_q.p_idx] = wr_val; // see R12
					c_d.st             = C_NVWR;
					c_d.cnt            = NV_WRITE_CNT;
					c_d.busy           = 1'b1; // see R19
				end else if (commit && c_q.ven) begin
					c_d.vol[c_q.p_idx] = wr_val; // see R11
					c_d.ven            = ven_rise; // an enable seen in this cycle wins over the clear
				end
				// neither enable: write dropped, see R18
			end
			C_NVWR: begin
				c_d.cnt = c_q.cnt - 8'h01;
				if (c_q.cnt == 8'h01) begin
					c_d.st   = C_IDLE;
					c_d.busy = 1'b0;
					c_d.write_enable_latch  = 1'b0;
					c_d.ven  = 1'b0;
				end
			end
			default: begin
				c_d.st = C_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c_q      <= '0;
			c_q.st   <= C_LOAD;
			c_q.busy <= 1'b1;
			c_q.cs_m <= 1'b1;
			c_q.cs_s <= 1'b1;
			c_q.cs_l <= 1'b1;
			c_q.vol  <= {NUM_REGS{VOL_RESET}};
		end else begin
			c_q <= c_d;
		end
	end

	// first-register fields to the protection logic
	assign reg_protect_ctl_lo_o  = c_q.vol[0][BIT_PROT_LO]; // see R13
	assign protect_granularity_o = c_q.vol[0][BIT_GRAN]; // see R14
	assign protect_direction_o   = c_q.vol[0][BIT_DIR]; // see R15
	assign protect_extent_o      = c_q.vol[0][EXT_HI:EXT_LO]; // see R16
	assign write_enable_latch_o  = c_q.write_enable_latch; // see R17, see R18
	assign busy_flag_o           = c_q.busy; // see R19

	// link-side checks
	dir_read_a: assert property (@(posedge sck_i) disable iff (cs_n_i) // see R1
		(l_q.st == S_CMD && rx_done && rx_byte == CMD_RD_SR2) |=> (l_q.st == S_OUT && l_q.rd == c_q.snap[1]))
		else $error("dedicated read did not select register two");
	dir_write_a: assert property (@(posedge sck_i) disable iff (cs_n_i) // see R2
		(l_q.st == S_CMD && rx_done && rx_byte == CMD_WR_SR3) |=> (l_q.st == S_DATA && l_q.sel == SEL_SR3))
		else $error("dedicated write did not target register three");
	ind_read_a: assert property (@(posedge sck_i) disable iff (cs_n_i) // see R5
		(l_q.st == S_SEL && rx_done && l_q.cmd == CMD_RD_IND && rx_byte == 8'h06)
		|=> (l_q.rd == c_q.snap[5]))
		else $error("indirect read of register six returned wrong byte");
	rsv_read_a: assert property (@(posedge sck_i) disable iff (cs_n_i) // see R9
		(l_q.st == S_SEL && rx_done && l_q.cmd == CMD_RD_IND && !sel_ok(rx_byte)) |=> (l_q.rd == RSV_READ))
		else $error("reserved select did not read constant");
	rsv_write_a: assert property (@(posedge sck_i) disable iff (cs_n_i) // see R9
		(l_q.st == S_DATA && rx_done && !sel_ok(l_q.sel)) |-> (l_d.wr_f == l_q.wr_f))
		else $error("reserved select raised a write");
	ind_write_a: assert property (@(posedge sck_i) disable iff (cs_n_i) // see R6
		(l_q.st == S_DATA && rx_done && l_q.sel == 8'h04) |-> (l_d.wr_f && l_d.wr_idx == 3'h3 && l_d.wr_data == rx_byte))
		else $error("indirect write lost its register index");

	// core-side checks
	pwrup_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R10
		(c_q.st == C_LOAD) |=> (c_q.vol[$past(c_q.idx)] == $past(ld_val)))
		else $error("power-up load copied wrong value");
	pwrup_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R10
		$fell(rst_i) |-> ##[5:7] (c_q.st == C_IDLE && !c_q.busy))
		else $error("power-up load did not finish in time");
	vol_only_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R11
		(commit && !c_q.write_enable_latch && c_q.ven) |-> !nv_we ##1 (c_q.vol[$past(c_q.p_idx)] == $past(wr_val)))
		else $error("volatile-only write misbehaved");
	both_copy_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R12
		(commit && c_q.write_enable_latch) |-> nv_we ##1 (c_q.vol[$past(c_q.p_idx)] == $past(wr_val) && c_q.busy))
		else $error("enabled write did not update both copies");
	reject_wr_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R18
		(commit && !c_q.write_enable_latch && !c_q.ven) |-> !nv_we ##1 $stable(c_q.vol))
		else $error("write accepted without enable");
	wel_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R17
		(en_rise && c_q.st != C_NVWR) |=> c_q.write_enable_latch)
		else $error("write enable latch not set");
	busy_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R19
		nv_we |=> busy_flag_o [*8])
		else $error("busy flag dropped during stored write");
	ro_bits_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R17
		c_q.vol[0][1:0] == 2'b00)
		else $error("read-only bits stored in first register");

	ind_rd_c: cover property (@(posedge sck_i) disable iff (cs_n_i)
		l_q.st == S_SEL && rx_done && l_q.cmd == CMD_RD_IND);
	nv_wr_c: cover property (@(posedge clk_i) disable iff (rst_i) nv_we);
	vol_wr_c: cover property (@(posedge clk_i) disable iff (rst_i) commit && !c_q.write_enable_latch && c_q.ven);
	rej_wr_c: cover property (@(posedge clk_i) disable iff (rst_i) commit && !c_q.write_enable_latch && !c_q.ven);

endmodule // sra_top
`default_nettype wire

// ---- sra_pkg.sv ----
// constants, encodings and state types of the status register access unit
// assumes a serial link in spi mode 0 and a 100 mhz core clock
package sra_pkg;

	// register count and register-select encoding
	localparam int         NUM_REGS   = 6;
	localparam logic [7:0] SEL_FIRST  = 8'h01;
	localparam logic [7:0] SEL_LAST   = 8'h06;
	localparam logic [7:0] SEL_SR1    = 8'h01;
	localparam logic [7:0] SEL_SR2    = 8'h02;
	localparam logic [7:0] SEL_SR3    = 8'h03;
	localparam logic [7:0] RSV_READ   = 8'h00;

	// opcodes
	localparam logic [7:0] CMD_RD_SR1 = 8'h05;
	localparam logic [7:0] CMD_RD_SR2 = 8'h35;
	localparam logic [7:0] CMD_RD_SR3 = 8'h15;
	localparam logic [7:0] CMD_WR_SR1 = 8'h01;
	localparam logic [7:0] CMD_WR_SR2 = 8'h31;
	localparam logic [7:0] CMD_WR_SR3 = 8'h11;
	localparam logic [7:0] CMD_RD_IND = 8'h65;
	localparam logic [7:0] CMD_WR_IND = 8'h71;
	localparam logic [7:0] CMD_WREN   = 8'h06;
	localparam logic [7:0] CMD_VWREN  = 8'h50;

	// field positions of the first register
	localparam int BIT_PROT_LO = 7;
	localparam int BIT_GRAN    = 6;
	localparam int BIT_DIR     = 5;
	localparam int EXT_HI      = 4;
	localparam int EXT_LO      = 2;
	localparam int BIT_WEL     = 1;
	localparam int BIT_BUSY    = 0;
	localparam logic [7:0] SR1_RO_MASK = 8'h03;

	// values after reset and of an unwritten non-volatile copy
	localparam logic [7:0] VOL_RESET  = 8'h00;
	localparam logic [7:0] NV_DEFAULT = 8'h00;

	// non-volatile write time, a least time so rounded up
	localparam int CLK_PERIOD_NS = 10;
	localparam int NV_WRITE_NS   = 1000;
	localparam int NV_WRITE_CYC  = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] NV_WRITE_CNT = 8'(NV_WRITE_CYC);

	typedef enum logic [2:0] {S_CMD, S_SEL, S_DATA, S_OUT, S_IGN} sra_link_e;
	typedef enum logic [1:0] {C_LOAD, C_IDLE, C_NVWR} sra_core_e;

endpackage

// ---- sra_nvstore.sv ----
// non-volatile copy of the six status registers
// assumes the writer keeps indices below the register count
`timescale 1ns/1ps
`default_nettype none
module sra_nvstore
	import sra_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       we_i,
	input  wire logic [2:0] wr_idx_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic [2:0] rd_idx_i,
	output logic      [7:0] rd_data_o
);

	// not touched by the core reset: contents survive it
	logic [7:0] mem_q [NUM_REGS] = '{default: NV_DEFAULT};

	// single write port
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[wr_idx_i] <= wr_data_i;
		end
	end

	assign rd_data_o = mem_q[rd_idx_i];

endmodule // sra_nvstore
`default_nettype wire

// ---- sra_shift.sv ----
// bit shifter of the serial link, clocked by the link clock
// assumes spi mode 0; chip select high clears all link state
`timescale 1ns/1ps
`default_nettype none
module sra_shift (
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic       mosi_i,
	input  wire logic [7:0] tx_byte_i,
	output logic      [7:0] rx_byte_o,
	output logic            rx_done_o,
	output logic            miso_o
);

	typedef struct packed {
		logic [2:0] cnt;
		logic [6:0] sh;
	} sra_rx_s;

	typedef struct packed {
		logic [7:0] sh;
	} sra_tx_s;

	sra_rx_s rx_q, rx_d;
	sra_tx_s tx_q, tx_d;

	// receive: sample on rising edge, msb first
	always_comb begin
		rx_d     = rx_q;
		rx_d.cnt = rx_q.cnt + 3'h1;
		rx_d.sh  = {rx_q.sh[5:0], mosi_i};
	end

	always_ff @(posedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			rx_q <= '0;
		end else begin
			rx_q <= rx_d;
		end
	end

	// transmit: reload at each byte boundary so the msb is out before the next rise
	always_comb begin
		tx_d = tx_q;
		if (rx_q.cnt == 3'h0) begin
			tx_d.sh = tx_byte_i;
		end else begin
			tx_d.sh = {tx_q.sh[6:0], 1'b0};
		end
	end

	always_ff @(negedge sck_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			tx_q <= '0;
		end else begin
			tx_q <= tx_d;
		end
	end

	assign rx_byte_o = {rx_q.sh, mosi_i}; // complete byte at the eighth rise
	assign rx_done_o = (rx_q.cnt == 3'h7);
	assign miso_o    = tx_q.sh[7];

endmodule // sra_shift
`default_nettype wire

// ---- sra_host.sv ----
// host side model of the serial link: issues frames of one to three bytes
// assumes spi mode 0; the 48 ns link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module sra_host (
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i,
	input  wire logic miso_oe_i
);
	localparam int HALF_NS = 24;

	// idle levels at time zero: clock low, deselected
	initial begin
		sck_o  = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// one frame; returns the bits heard during the last byte and whether enable stood over all of them
	task automatic frame(input logic [23:0] bytes, input int n, output logic [7:0] rd, output logic oe_all);
		logic [7:0] b;
		rd = 8'h00;
		oe_all = 1'b1;
		cs_n_o = 1'b0;
		#40;
		for (int i = 0; i < n; i++) begin
			b = bytes[23 - 8 * i -: 8]; // every byte, select included, goes out whole
			oe_all = 1'b1;
			for (int k = 7; k >= 0; k--) begin
				mosi_o = b[k];
				#HALF_NS sck_o = 1'b1;
				rd = {rd[6:0], miso_i};
				oe_all = oe_all & miso_oe_i;
				#HALF_NS sck_o = 1'b0;
			end
		end
		#HALF_NS cs_n_o = 1'b1;
		// released line must not keep showing the last bit
		mosi_o = ~mosi_o;
		// gap lets the core see the frame end and commit before the next one
		#100;
	endtask
endmodule // sra_host
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench of the status register access unit
// assumes the host model drives the link; the core clock runs at 100 mhz
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sra_pkg::*;
	logic       clk_i;
	logic       rst_i;
	logic       sck, cs_n, mosi, miso, miso_oe;
	logic       prot_lo, gran, dir, write_enable_latch, busy;
	logic [2:0] ext;
	logic [7:0] pins;
	int         mismatches;
	int         checks_done;

	assign pins = {prot_lo, gran, dir, ext, write_enable_latch, busy};

	// core clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	sra_host host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));
	sra_top dut (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
		.miso_oe_o(miso_oe), .reg_protect_ctl_lo_o(prot_lo), .protect_granularity_o(gran),
		.protect_direction_o(dir), .protect_extent_o(ext), .write_enable_latch_o(write_enable_latch), .busy_flag_o(busy));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// reset for 8 cycles, then the power-up load keeps busy up for a few cycles
	task automatic do_reset();
		@(negedge clk_i) rst_i = 1'b1;
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		check({7'h00, busy}, 8'h01, "busy during load");
		repeat (10) @(negedge clk_i);
		check({7'h00, busy}, 8'h00, "busy after load");
	endtask

	task automatic cmd(input logic [7:0] op);
		logic [7:0] r;
		logic       oe;
		host.frame({op, 16'h0000}, 1, r, oe);
	endtask

	task automatic wr(input logic [23:0] b, input int n);
		logic [7:0] r;
		logic       oe;
		host.frame(b, n, r, oe);
	endtask

	// read frame: the last byte is the answer, with the output enable standing over it
	task automatic rd(input logic [23:0] b, input int n, input logic [7:0] exp, input string msg);
		logic [7:0] r;
		logic       oe;
		host.frame(b, n, r, oe);
		check(r, exp, msg);
		check({7'h00, oe}, 8'h01, "read enable");
	endtask

	// after reset every register and protection pin reads zero
	task automatic t_power_up();
		check(pins, VOL_RESET, "pins after reset");
		for (int s = 1; s <= NUM_REGS; s++)
			rd({CMD_RD_IND, 8'(s), 8'h00}, 3, NV_DEFAULT, "reset value");
	endtask

	// a write with no enable before it leaves everything alone
	task automatic t_unenabled();
		wr({CMD_WR_SR1, 8'hfc, 8'h00}, 2);
		wr({CMD_WR_IND, SEL_SR2, 8'h55}, 3);
		check(pins, 8'h00, "pins after refused write");
		rd({CMD_RD_SR2, 16'h0000}, 2, 8'h00, "refused indirect write");
	endtask

	// dedicated opcodes after a volatile enable; the latch stays clear
	task automatic t_direct();
		logic [7:0] wcmd [3] = '{CMD_WR_SR1, CMD_WR_SR2, CMD_WR_SR3};
		logic [7:0] rcmd [3] = '{CMD_RD_SR1, CMD_RD_SR2, CMD_RD_SR3};
		logic [7:0] dat [3] = '{8'hff, 8'h5a, 8'hc3};
		logic [7:0] exp;
		for (int i = 0; i < 3; i++) begin
			cmd(CMD_VWREN);
			check({7'h00, write_enable_latch}, 8'h00, "latch after volatile enable");
			wr({wcmd[i], dat[i], 8'h00}, 2);
			exp = (i == 0) ? (dat[i] & ~SR1_RO_MASK) : dat[i];
			rd({rcmd[i], 16'h0000}, 2, exp, "direct read");
		end
		check(pins, 8'hfc, "protect pins set");
	endtask

	// indirect writes to all six, reserved selects, then read back both ways
	task automatic t_indirect();
		logic [7:0] rsv [3] = '{8'h00, 8'h07, 8'hff};
		logic [7:0] rcmd [3] = '{CMD_RD_SR1, CMD_RD_SR2, CMD_RD_SR3};
		logic [7:0] exp;
		for (int s = 1; s <= NUM_REGS; s++) begin
			cmd(CMD_VWREN);
			wr({CMD_WR_IND, 8'(s), 8'(8'h20 * s + s)}, 3);
		end
		check(pins, 8'h20, "pins after indirect write");
		for (int i = 0; i < 3; i++) begin
			cmd(CMD_VWREN);
			wr({CMD_WR_IND, rsv[i], 8'haa}, 3);
			rd({CMD_RD_IND, rsv[i], 8'h00}, 3, RSV_READ, "reserved read");
		end
		for (int s = 1; s <= NUM_REGS; s++) begin
			exp = (s == 1) ? 8'h20 : 8'(8'h20 * s + s);
			rd({CMD_RD_IND, 8'(s), 8'h00}, 3, exp, "indirect read");
			if (s <= 3)
				rd({rcmd[s - 1], 16'h0000}, 2, exp, "direct after indirect");
		end
	endtask

	// wait for the non-volatile write to end and report how many cycles busy stood after the call
	task automatic wait_nv(output int cnt);
		cnt = 0;
		while (busy !== 1'b0 && cnt < 300) begin
			@(negedge clk_i);
			cnt++;
		end
	endtask

	// non-volatile writes survive a reset, volatile ones do not
	task automatic t_nv();
		int cnt;
		cmd(CMD_WREN);
		check({7'h00, write_enable_latch}, 8'h01, "latch after write enable");
		rd({CMD_RD_SR1, 16'h0000}, 2, 8'h22, "latch bit in first register");
		wr({CMD_WR_IND, 8'h05, 8'ha5}, 3);
		check({7'h00, busy}, 8'h01, "busy during nv write");
		wait_nv(cnt);
		check({7'h00, (cnt > 80 && cnt < NV_WRITE_CYC)}, 8'h01, "nv write length");
		check({6'h00, write_enable_latch, busy}, 8'h00, "latch and busy after nv write");
		cmd(CMD_WREN);
		wr({CMD_WR_SR1, 8'ha8, 8'h00}, 2);
		rd({CMD_RD_SR1, 16'h0000}, 2, 8'hab, "busy bit in first register");
		wait_nv(cnt);
		cmd(CMD_VWREN);
		wr({CMD_WR_IND, 8'h05, 8'h3c}, 3);
		rd({CMD_RD_IND, 8'h05, 8'h00}, 3, 8'h3c, "volatile write");
		do_reset();
		rd({CMD_RD_IND, 8'h05, 8'h00}, 3, 8'ha5, "nv copy loaded");
		rd({CMD_RD_SR2, 16'h0000}, 2, NV_DEFAULT, "volatile lost");
		check(pins, 8'ha8, "protect pins from nv");
	endtask

	// watchdog: the whole sequence needs well under 200 us
	initial begin
		#500000;
		mismatches++;
		stop_test();
	end

	initial begin
		mismatches = 0;
		checks_done = 0;
		rst_i = 1'b1;
		do_reset();
		t_power_up();
		t_unenabled();
		t_direct();
		t_indirect();
		t_nv();
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
